// ===== rtl/crtc_top.sv
// Real-time counter: prescaler, 43-bit calendar or binary counter, alarm
// comparator and interrupt, reached over an Avalon-MM slave.
// Assumes one clock, a synchronous reset and a master that holds its request.
`timescale 1ns/1ps
`include "crtc_defines.svh"
module crtc_top
#(
   parameter int PRE_W = `CRTC_PRE_W
)
(
   // Clock, reset, enable
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   // Avalon-MM slave
   input wire logic [5:0] avsAddress,
   input wire logic avsRead,
   input wire logic avsWrite,
   input wire logic [3:0] avsByteEnable,
   input wire logic [31:0] avsWriteData,
   output logic [31:0] avsReadData,
   output logic avsWaitRequest,
   // Events
   output logic rtcMatch,
   output logic irq
);
   // Merge write data into a word under byte enables
   function automatic logic [31:0] mergeBe(input logic [31:0] old,
                                           input logic [31:0] wd,
                                           input logic [3:0] be);
      for (int i = 0; i < 4; i++)
         old[i*8 +: 8] = be[i] ? wd[i*8 +: 8] : old[i*8 +: 8];
      mergeBe = old;
   endfunction

   // Bus state
   crtc_pkg::crtc_bus_t bus_q; // Idle or answering
   crtc_pkg::crtc_bus_t bus_d;
   logic wait_q; // Waitrequest flop
   logic [31:0] readData_q; // Read answer

   // Control registers
   crtc_pkg::crtc_mode_t mode_q; // Counting mode
   logic run_q; // Prescaler running
   logic [PRE_W-1:0] prescale_q; // Divide value
   logic [42:0] alarm_q; // Alarm compare value
   logic [10:0] snapHi_q; // Upper counter bits caught on a low read

   // Counter and outputs
   logic [42:0] count_q; // Time or binary count
   logic [42:0] count_d;
   logic match_q; // Comparator output
   logic [1:0] irqStat_q; // Sticky events
   logic [1:0] irqEn_q; // Event enables
   logic irq_q; // Interrupt line

   // Strobe from the prescaler
   logic tick;

   // Request decode
   wire reqValid = avsRead || avsWrite;
   wire accept = ce && (bus_q == crtc_pkg::BUS_IDLE) && reqValid;
   wire commit = ce && (bus_q == crtc_pkg::BUS_ACK) && avsWrite;
   wire rdAccept = accept && avsRead;
   wire hitCtrl = (avsAddress == `CRTC_OFF_CTRL);
   wire hitPre = (avsAddress == `CRTC_OFF_PRESCALE);
   wire hitCntLo = (avsAddress == `CRTC_OFF_COUNT_LO);
   wire hitCntHi = (avsAddress == `CRTC_OFF_COUNT_HI);
   wire hitAlmLo = (avsAddress == `CRTC_OFF_ALARM_LO);
   wire hitAlmHi = (avsAddress == `CRTC_OFF_ALARM_HI);
   wire hitStat = (avsAddress == `CRTC_OFF_IRQ_STATUS);
   wire hitClr = (avsAddress == `CRTC_OFF_IRQ_CLEAR);
   wire hitEn = (avsAddress == `CRTC_OFF_IRQ_ENABLE);

   // Word views of the registers
   wire [31:0] ctrlWord = {30'h0, run_q, mode_q};
   wire [31:0] preWord = 32'(prescale_q);
   wire [31:0] cntHiWord = {21'h0, count_q[42:32]};
   wire [31:0] almHiWord = {21'h0, alarm_q[42:32]};

   // Merged write values
   wire [31:0] ctrlW = mergeBe(ctrlWord, avsWriteData, avsByteEnable);
   wire [31:0] preW = mergeBe(preWord, avsWriteData, avsByteEnable);
   wire [31:0] cntLoW = mergeBe(count_q[31:0], avsWriteData, avsByteEnable);
   wire [31:0] cntHiW = mergeBe(cntHiWord, avsWriteData, avsByteEnable);
   wire [31:0] almLoW = mergeBe(alarm_q[31:0], avsWriteData, avsByteEnable);
   wire [31:0] almHiW = mergeBe(almHiWord, avsWriteData, avsByteEnable);
   wire [1:0] lowW = avsByteEnable[0] ? avsWriteData[1:0] : 2'h0;

   // Read multiplexer; unmapped offsets and the clear register read zero
   wire [31:0] readMux =
      hitCtrl ? ctrlWord :
      hitPre ? preWord :
      hitCntLo ? count_q[31:0] :
      hitCntHi ? {21'h0, snapHi_q} :
      hitAlmLo ? alarm_q[31:0] :
      hitAlmHi ? almHiWord :
      hitStat ? {30'h0, irqStat_q} :
      hitEn ? {30'h0, irqEn_q} : 32'h0000_0000;

   // A mode change reloads that mode's reset values
   wire newMode = ctrlW[`CRTC_CTRL_MODE];
   wire modeReload = commit && hitCtrl && (newMode != mode_q); // [R1]
   wire cntWrite = commit && (hitCntLo || hitCntHi);
   wire step = ce && tick && !cntWrite && !modeReload; // [R2]

   // Next count from the step logic
   logic [42:0] stepVal;
   crtc_cal_step crtc_cal_step_inst
   (
      .cur(count_q),
      .calMode(mode_q == crtc_pkg::MODE_CALENDAR),
      .nxt(stepVal)
   );

   // Prescaler
   crtc_prescaler #(.PRE_W(PRE_W)) crtc_prescaler_inst
   (
      .clk(clk),
      .rst(rst),
      .ce(ce),
      .run(run_q),
      .divide(prescale_q),
      .tick(tick)
   );

   // Counter next value: reload, then software write, then strobe
   assign count_d =
      modeReload ? (newMode ? `CRTC_CAL_RST : `CRTC_BIN_RST) : // [R1]
      (commit && hitCntLo) ? {count_q[42:32], cntLoW} :
      (commit && hitCntHi) ? {cntHiW[10:0], count_q[31:0]} :
      step ? stepVal : count_q; // [R2] [R15]

   // Comparator, registered so the pin comes from a flop
   wire matchNow = (count_q == alarm_q); // [R14]

   // Interrupt events; a set in the clearing cycle survives
   wire [1:0] events = {matchNow && !match_q, step};
   wire [1:0] clrMask = (commit && hitClr) ? lowW : 2'h0;
   wire [1:0] irqStat_d = (irqStat_q & ~clrMask) | events;

   // Bus slave: one answer cycle after each accepted request
   assign bus_d = accept ? crtc_pkg::BUS_ACK : crtc_pkg::BUS_IDLE;

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         bus_q <= crtc_pkg::BUS_IDLE;
         wait_q <= 1'b1;
         readData_q <= 32'h0000_0000;
      end
      else if (ce)
      begin
         bus_q <= bus_d;
         wait_q <= (bus_d != crtc_pkg::BUS_ACK);
         if (rdAccept)
            readData_q <= readMux;
      end
   end

   // Control registers; writes take effect in the answer cycle
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         mode_q <= crtc_pkg::crtc_mode_t'(`CRTC_MODE_RST);
         run_q <= `CRTC_RUN_RST;
         prescale_q <= PRE_W'(`CRTC_PRE_RST);
         alarm_q <= `CRTC_BIN_RST;
         irqEn_q <= 2'h0;
      end
      else if (commit)
      begin
         if (hitCtrl)
         begin
            mode_q <= crtc_pkg::crtc_mode_t'(newMode); // [R1]
            run_q <= ctrlW[`CRTC_CTRL_RUN];
         end
         if (hitPre)
            prescale_q <= preW[PRE_W-1:0];
         if (hitAlmLo)
            alarm_q[31:0] <= almLoW;
         if (hitAlmHi)
            alarm_q[42:32] <= almHiW[10:0];
         if (hitEn)
            irqEn_q <= lowW;
      end
   end

   // Counter, snapshot, comparator and interrupt
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         // Reset mode is calendar, so calendar reset values load
         count_q <= `CRTC_CAL_RST; // [R6] [R9] [R10] [R12] [R13]
         snapHi_q <= 11'h000;
         match_q <= 1'b0;
         irqStat_q <= 2'h0;
         irq_q <= 1'b0;
      end
      else if (ce)
      begin
         count_q <= count_d;
         // Low read freezes the high half so the pair is coherent
         if (rdAccept && hitCntLo)
            snapHi_q <= count_q[42:32];
         match_q <= matchNow; // [R14]
         irqStat_q <= irqStat_d;
         irq_q <= |(irqStat_d & irqEn_q);
      end
   end

   assign avsReadData = readData_q;
   assign avsWaitRequest = wait_q;
   assign rtcMatch = match_q;
   assign irq = irq_q;

   // Field views for checking
   wire [5:0] secF = count_q[`CRTC_SEC_LSB +: 6];
   wire [5:0] minF = count_q[`CRTC_MIN_LSB +: 6];
   wire [4:0] hourF = count_q[`CRTC_HOUR_LSB +: 5];
   wire [4:0] dayF = count_q[`CRTC_DAY_LSB +: 5];
   wire [3:0] monF = count_q[`CRTC_MON_LSB +: 4];
   wire [7:0] yearF = count_q[`CRTC_YEAR_LSB +: 8];
   wire [2:0] wdayF = count_q[`CRTC_WDAY_LSB +: 3];
   wire [5:0] weekF = count_q[`CRTC_WEEK_LSB +: 6];
   wire calOn = (mode_q == crtc_pkg::MODE_CALENDAR);
   wire endDay = (secF == 6'h3B) && (minF == 6'h3B) && (hourF == 5'h17);

   mode_reload_a: // [R1]
      assert property (@(posedge clk) disable iff (rst)
         modeReload |=> (count_q == (calOn ? `CRTC_CAL_RST : `CRTC_BIN_RST)))
      else $error("mode change did not load reset values");
   strobe_step_a: // [R2]
      assert property (@(posedge clk) disable iff (rst)
         (ce && !tick) |=> $stable(count_q) || $past(cntWrite)
            || $past(modeReload))
      else $error("counter moved without a strobe");
   binary_inc_a: // [R5]
      assert property (@(posedge clk) disable iff (rst)
         (step && !calOn) |=> (count_q == $past(count_q) + 43'h1))
      else $error("binary counter did not increment by one");
   sec_carry_a: // [R6]
      assert property (@(posedge clk) disable iff (rst)
         (step && calOn && secF == 6'h3B && minF < 6'h3B)
            |=> (secF == 6'h00) && (minF == $past(minF) + 6'h01))
      else $error("seconds did not wrap into minutes");
   min_carry_a: // [R7]
      assert property (@(posedge clk) disable iff (rst)
         (step && calOn && secF == 6'h3B && minF == 6'h3B && hourF < 5'h17)
            |=> (minF == 6'h00) && (hourF == $past(hourF) + 5'h01))
      else $error("minutes did not wrap into hours");
   feb_end_a: // [R9]
      assert property (@(posedge clk) disable iff (rst)
         (step && calOn && endDay && dayF == 5'h1C && monF == 4'h2
            && yearF == 8'h64) |=> (dayF == 5'h01) && (monF == 4'h3)
            && (hourF == 5'h00))
      else $error("short February did not roll to March");
   year_roll_a: // [R10] [R11]
      assert property (@(posedge clk) disable iff (rst)
         (step && calOn && endDay && dayF == 5'h1F && monF == 4'hC)
            |=> (monF == 4'h1) && (yearF == $past(yearF) + 8'h01))
      else $error("December end did not start a new year");
   week_roll_a: // [R12] [R13]
      assert property (@(posedge clk) disable iff (rst)
         (step && calOn && endDay && wdayF == 3'h7 && weekF == 6'h34)
            |=> (wdayF == 3'h1) && (weekF == 6'h01))
      else $error("weekday or week did not wrap");
   match_out_a: // [R14]
      assert property (@(posedge clk) disable iff (rst)
         (ce && count_q == alarm_q) |=> rtcMatch ##1 (rtcMatch ||
            $past(count_q) != $past(alarm_q) || !$past(ce)))
      else $error("match output missed an equal compare");
   reset_vals_a: // [R8] [R12]
      assert property (@(posedge clk)
         rst |=> (count_q == `CRTC_CAL_RST) && calOn)
      else $error("reset did not load calendar values");
endmodule

// ===== rtl/crtc_defines.svh
// Offsets, field positions, reset values and widths of the real-time counter.
// Assumes byte addressing on the register bus, one 32-bit word per register.
//
// Summary of operation
// R1: Mode bit: 1 calendar, 0 binary counting.
// R2: Prescaler strobe advances counter by one.
// R3: Software sets prescaler to 1 Hz in calendar; the bench uses a 64-cycle period, since 1 Hz is out of reach at 250 MHz.
// R4: Binary mode accepts any prescaler division.
// R5: Binary mode: 43-bit linear up-counter.
// R6: Seconds: 6 bits, 0-59 or 0-63, reset 0.
// R7: Minutes: 6 bits, 0-59 or 0-63, reset 0.
// R8: Hours: 5 bits, 0-23 or 0-31, reset 0.
// R9: Day: 5 bits, month/leap aware, reset 1/0.
// R10: Month: 4 bits, 1-12, reset 1/0.
// R11: Year: 8 bits, 2000-2255, reset 0.
// R12: Weekday: 3 bits, 1-7, reset 7/0.
// R13: Week: 6 bits, 1-52, reset 1/0.
// R14: Match output high while alarm equals counter.
// R15: Fields wrap to minimum and carry; binary wraps.
`ifndef CRTC_DEFINES_SVH
`define CRTC_DEFINES_SVH

// Widths
`define CRTC_CNT_W 43
`define CRTC_PRE_W 26

// Register byte offsets
`define CRTC_OFF_CTRL 6'h00
`define CRTC_OFF_PRESCALE 6'h04
`define CRTC_OFF_COUNT_LO 6'h08
`define CRTC_OFF_COUNT_HI 6'h0C
`define CRTC_OFF_ALARM_LO 6'h10
`define CRTC_OFF_ALARM_HI 6'h14
`define CRTC_OFF_IRQ_STATUS 6'h18
`define CRTC_OFF_IRQ_CLEAR 6'h1C
`define CRTC_OFF_IRQ_ENABLE 6'h20

// Control and interrupt bit positions
`define CRTC_CTRL_MODE 0
`define CRTC_CTRL_RUN 1
`define CRTC_IRQ_TICK 0
`define CRTC_IRQ_MATCH 1

// Field positions inside the 43-bit counter
`define CRTC_SEC_LSB 0
`define CRTC_MIN_LSB 6
`define CRTC_HOUR_LSB 12
`define CRTC_DAY_LSB 17
`define CRTC_MON_LSB 22
`define CRTC_YEAR_LSB 26
`define CRTC_WDAY_LSB 34
`define CRTC_WEEK_LSB 37

// Reset values
`define CRTC_CAL_RST 43'h3C_0042_0000
`define CRTC_BIN_RST 43'h000_0000_0000
`define CRTC_MODE_RST 1'h1
`define CRTC_RUN_RST 1'h1
`define CRTC_PRE_RST 26'h3FF_FFFF

`endif

// ===== rtl/crtc_pkg.sv
// Types shared by the real-time counter modules.
// Assumes the constants come from crtc_defines.svh.
package crtc_pkg;
   // Counting modes, coded as the mode-select bit
   typedef enum logic [0:0]
   {
      MODE_BINARY = 1'b0,
      MODE_CALENDAR = 1'b1
   } crtc_mode_t;

   // Register bus slave states
   typedef enum logic [0:0]
   {
      BUS_IDLE = 1'b0,
      BUS_ACK = 1'b1
   } crtc_bus_t;
endpackage

// ===== rtl/crtc_prescaler.sv
// Prescaler: divides the clock into a one-cycle counting strobe.
// Assumes the divide value changes only while the block is quiet.
`timescale 1ns/1ps
module crtc_prescaler
#(
   parameter int PRE_W = 26
)
(
   // Clock, reset, enable
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   // Control
   input wire logic run,
   input wire logic [PRE_W-1:0] divide,
   // Strobe, one cycle every divide+1 cycles
   output logic tick
);
   logic [PRE_W-1:0] cnt_q; // Cycles since last strobe
   logic tick_q; // Registered strobe
   wire atEnd = (cnt_q >= divide); // Catches a divide lowered mid-count

   // Count up and emit the strobe at the terminal value
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         cnt_q <= '0;
         tick_q <= 1'b0;
      end
      else if (ce)
      begin
         // Stopped: hold the phase at zero so restart is a full period
         if (!run)
         begin
            cnt_q <= '0;
            tick_q <= 1'b0;
         end
         else
         begin
            cnt_q <= atEnd ? '0 : cnt_q + PRE_W'(1); // [R2]
            tick_q <= atEnd; // [R2]
         end
      end
   end

   assign tick = tick_q;
endmodule

// ===== rtl/crtc_cal_step.sv
// Next-value logic of the 43-bit counter for both counting modes.
// Assumes calendar fields hold legal values; illegal ones still advance.
`timescale 1ns/1ps
`include "crtc_defines.svh"
module crtc_cal_step
(
   // Current value and mode
   input wire logic [42:0] cur,
   input wire logic calMode,
   // Value after one strobe
   output logic [42:0] nxt
);
   // Last day of a month; years 2100 and 2200 are not leap years
   function automatic logic [4:0] lastDay(input logic [3:0] m,
                                          input logic [7:0] y);
      logic leap;
      leap = (y[1:0] == 2'h0) && (y != 8'h64) && (y != 8'hC8);
      case (m)
         4'h2: lastDay = leap ? 5'h1D : 5'h1C;
         4'h4, 4'h6, 4'h9, 4'hB: lastDay = 5'h1E;
         default: lastDay = 5'h1F;
      endcase
   endfunction

   // Field views
   wire [5:0] sec = cur[`CRTC_SEC_LSB +: 6];
   wire [5:0] min = cur[`CRTC_MIN_LSB +: 6];
   wire [4:0] hour = cur[`CRTC_HOUR_LSB +: 5];
   wire [4:0] day = cur[`CRTC_DAY_LSB +: 5];
   wire [3:0] mon = cur[`CRTC_MON_LSB +: 4];
   wire [7:0] year = cur[`CRTC_YEAR_LSB +: 8];
   wire [2:0] wday = cur[`CRTC_WDAY_LSB +: 3];
   wire [5:0] week = cur[`CRTC_WEEK_LSB +: 6];

   // Carry chain; >= keeps out-of-range values from running away
   wire secWrap = (sec >= 6'h3B); // [R6] [R15]
   wire minWrap = secWrap && (min >= 6'h3B); // [R7] [R15]
   wire hourWrap = minWrap && (hour >= 5'h17); // [R8] [R15]
   wire dayWrap = hourWrap && (day >= lastDay(mon, year)); // [R9] [R15]
   wire monWrap = dayWrap && (mon >= 4'hC); // [R10] [R15]
   wire wdayWrap = hourWrap && (wday >= 3'h7); // [R12] [R15]
   wire weekWrap = wdayWrap && (week >= 6'h34); // [R13] [R15]

   // Calendar field next values
   wire [5:0] secN = secWrap ? 6'h00 : sec + 6'h01;
   wire [5:0] minN = !secWrap ? min : (minWrap ? 6'h00 : min + 6'h01);
   wire [4:0] hourN = !minWrap ? hour : (hourWrap ? 5'h00 : hour + 5'h01);
   wire [4:0] dayN = !hourWrap ? day : (dayWrap ? 5'h01 : day + 5'h01);
   wire [3:0] monN = !dayWrap ? mon : (monWrap ? 4'h1 : mon + 4'h1);
   wire [7:0] yearN = monWrap ? year + 8'h01 : year; // [R11]
   wire [2:0] wdayN = !hourWrap ? wday : (wdayWrap ? 3'h1 : wday + 3'h1);
   wire [5:0] weekN = !wdayWrap ? week : (weekWrap ? 6'h01 : week + 6'h01);

   wire [42:0] calN = {weekN, wdayN, yearN, monN, dayN, hourN, minN, secN};

   // Binary mode wraps to zero after all ones
   assign nxt = calMode ? calN : cur + 43'h000_0000_0001; // [R1] [R5]
endmodule

// ===== testbench/crtc_avm_master.sv
// Avalon-MM master model that stands in for software on the register bus.
// Assumes one clock; the testbench calls xfer for every register access.
`timescale 1ns/1ps
module crtc_avm_master
(
   // Clock
   input wire logic clk,
   // Answer from the slave
   input wire logic waitRequest,
   input wire logic [31:0] readData,
   // Request to the slave
   output logic [5:0] address,
   output logic read,
   output logic write,
   output logic [3:0] byteEnable,
   output logic [31:0] writeData
);
   // Quiet bus at time zero
   initial
   begin
      address = 6'h3F;
      read = 1'b0;
      write = 1'b0;
      byteEnable = 4'hF;
      writeData = 32'h0;
   end

   // One transfer: raise after an edge, hold until waitrequest is seen low
   task automatic xfer(input logic wr, input logic [5:0] a,
                       input logic [31:0] d, input logic [3:0] be,
                       output logic [31:0] q);
      @(posedge clk);
      address <= a;
      write <= wr;
      read <= !wr;
      byteEnable <= be;
      writeData <= d;
      // Wait as long as the slave needs; only the bench timeout ends a hang
      do
      begin
         @(posedge clk);
      end
      while (waitRequest !== 1'b0);
      q = readData;
      read <= 1'b0;
      write <= 1'b0;
      // Released address and data lines show inverted values so stale data is never trusted
      writeData <= ~d;
      address <= ~a;
   endtask
endmodule

// ===== testbench/tb_crtc_top.sv
// Self-checking bench for the real-time counter over its register bus.
// Assumes crtc_defines.svh offsets and one 250 MHz clock.
`timescale 1ns/1ps
`include "crtc_defines.svh"
module tb_crtc_top;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic ce = 1'b1; // Held high: freezing is not exercised
   wire logic [5:0] avsAddress;
   wire logic avsRead, avsWrite;
   wire logic [3:0] avsByteEnable;
   wire logic [31:0] avsWriteData;
   logic [31:0] avsReadData;
   logic avsWaitRequest, rtcMatch, irq;
   int err_count = 0;
   int cmp_count = 0;
   int cyc = 0;
   logic [31:0] rng = 32'h13B00C83; // Fixed seed keeps runs repeatable
   logic [42:0] got, v;
   logic [31:0] q;

   // 4 ns clock
   always #2 clk = ~clk;

   crtc_top crtc_top_inst (.clk(clk), .rst(rst), .ce(ce),
      .avsAddress(avsAddress), .avsRead(avsRead), .avsWrite(avsWrite),
      .avsByteEnable(avsByteEnable), .avsWriteData(avsWriteData),
      .avsReadData(avsReadData), .avsWaitRequest(avsWaitRequest),
      .rtcMatch(rtcMatch), .irq(irq));
   crtc_avm_master avm_inst (.clk(clk), .waitRequest(avsWaitRequest),
      .readData(avsReadData), .address(avsAddress), .read(avsRead),
      .write(avsWrite), .byteEnable(avsByteEnable),
      .writeData(avsWriteData));

   // Xorshift source for random counter values
   function automatic logic [31:0] xs();
      rng = rng ^ (rng << 13);
      rng = rng ^ (rng >> 17);
      rng = rng ^ (rng << 5);
      return rng;
   endfunction

   // Pack calendar fields into the 43-bit layout
   function automatic logic [42:0] mk(int s, int mi, int h, int d, int mo,
                                      int y, int wd, int wk);
      return {wk[5:0], wd[2:0], y[7:0], mo[3:0], d[4:0], h[4:0], mi[5:0],
              s[5:0]};
   endfunction

   // Days in a month; 2100 and 2200 are not leap years
   function automatic int mlen(int mo, int y);
      if (mo == 2)
         return (y % 4 == 0 && y != 100 && y != 200) ? 29 : 28;
      return (mo == 4 || mo == 6 || mo == 9 || mo == 11) ? 30 : 31;
   endfunction

   // Expected calendar value after one strobe
   function automatic logic [42:0] cal_next(logic [42:0] c);
      int s, mi, h, d, mo, y, wd, wk;
      {wk, wd, y, mo, d, h, mi, s} = {26'h0, c[42:37], 29'h0, c[36:34],
         24'h0, c[33:26], 28'h0, c[25:22], 27'h0, c[21:17], 27'h0,
         c[16:12], 26'h0, c[11:6], 26'h0, c[5:0]};
      s++;
      if (s == 60) begin s = 0; mi++; end
      if (mi == 60) begin mi = 0; h++; end
      if (h == 24)
      begin
         h = 0;
         d++;
         wd++;
         if (wd == 8) begin wd = 1; wk = (wk == 52) ? 1 : wk + 1; end
      end
      if (d > mlen(mo, y)) begin d = 1; mo++; end
      if (mo == 13) begin mo = 1; y = (y + 1) % 256; end
      return mk(s, mi, h, d, mo, y, wd, wk);
   endfunction

   task automatic chk(input string nm, input logic [42:0] s, input logic [42:0] e);
      cmp_count++;
      if (s !== e)
      begin
         err_count++;
         $display("unexpected %s expected %h seen %h", nm, e, s);
      end
   endtask

   task automatic wr(input logic [5:0] a, input logic [31:0] d);
      logic [31:0] t;
      avm_inst.xfer(1'b1, a, d, 4'hF, t);
   endtask

   task automatic rd(input logic [5:0] a, output logic [31:0] d);
      avm_inst.xfer(1'b0, a, 32'h0, 4'hF, d);
   endtask

   // Low word first so the high word comes from the same snapshot
   task automatic rdcnt(output logic [42:0] c);
      logic [31:0] lo, hi;
      rd(`CRTC_OFF_COUNT_LO, lo);
      rd(`CRTC_OFF_COUNT_HI, hi);
      c = {hi[10:0], lo};
   endtask

   task automatic setcnt(input logic [5:0] base, input logic [42:0] c);
      wr(base, c[31:0]);
      wr(base + 6'h04, {21'h0, c[42:32]});
   endtask

   // Run until the strobe flag shows, then stop well before the next one
   task automatic one_tick(input logic m);
      int n;
      wr(`CRTC_OFF_IRQ_CLEAR, 32'h1);
      wr(`CRTC_OFF_CTRL, {30'h0, 1'b1, m});
      n = 0;
      do
      begin
         rd(`CRTC_OFF_IRQ_STATUS, q);
         n++;
      end
      while (q[0] !== 1'b1 && n < 200);
      wr(`CRTC_OFF_CTRL, {30'h0, 1'b0, m});
   endtask

   task automatic step_case(input logic m, input logic [42:0] c);
      setcnt(`CRTC_OFF_COUNT_LO, c);
      one_tick(m);
      rdcnt(got);
      chk("count", got, m ? cal_next(c) : c + 43'h1);
   endtask

   task automatic final_report();
      $display("compares %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   // Cycle ceiling far above the few thousand cycles the tests need
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 50000)
      begin
         err_count++;
         final_report();
      end
   end

   initial
   begin
      int s, mi, h, mo, y;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      // Reset values
      rd(`CRTC_OFF_CTRL, q);
      chk("ctrl", {11'h0, q}, 43'h3);
      rd(`CRTC_OFF_PRESCALE, q);
      chk("prescale", {11'h0, q}, 43'h3FF_FFFF);
      rdcnt(got);
      chk("reset count", got, mk(0, 0, 0, 1, 1, 0, 7, 1));
      rd(6'h24, q);
      chk("unmapped", {11'h0, q}, 43'h0);
      rd(`CRTC_OFF_IRQ_STATUS, q);
      chk("status", {11'h0, q}, 43'h0);
      chk("irq", {42'h0, irq}, 43'h0);
      // One byte lane written; the other lanes keep their reset value
      avm_inst.xfer(1'b1, `CRTC_OFF_PRESCALE, 32'hA5A5_A511, 4'h1, q);
      rd(`CRTC_OFF_PRESCALE, q);
      chk("prescale lane", {11'h0, q}, 43'h3FF_FF11);
      $display("test reset done");
      // Period of 64 cycles: software picks the rate; 1 Hz is unreachable
      wr(`CRTC_OFF_PRESCALE, 32'h0000_003F);
      wr(`CRTC_OFF_CTRL, 32'h1);
      // Calendar corners: leap, century, year wrap, month ends
      step_case(1'b1, mk(59, 59, 23, 28, 2, 4, 7, 52));
      step_case(1'b1, mk(59, 59, 23, 28, 2, 100, 3, 10));
      step_case(1'b1, mk(59, 59, 23, 31, 12, 255, 7, 52));
      step_case(1'b1, mk(59, 59, 23, 30, 4, 8, 1, 1));
      step_case(1'b1, mk(59, 58, 23, 1, 1, 0, 1, 1));
      step_case(1'b1, mk(10, 0, 0, 1, 1, 0, 1, 1));
      for (int i = 0; i < 8; i++)
      begin
         mi = (xs() % 2) ? 59 : xs() % 60;
         h = (xs() % 2) ? 23 : xs() % 24;
         mo = 1 + xs() % 12;
         y = xs() % 256;
         step_case(1'b1, mk(59, mi, h, 1 + xs() % mlen(mo, y), mo, y,
                   1 + xs() % 7, 1 + xs() % 52));
      end
      $display("test calendar done");
      // Mode change loads the binary reset value
      wr(`CRTC_OFF_CTRL, 32'h0);
      rdcnt(got);
      chk("binary load", got, 43'h0);
      step_case(1'b0, {43{1'b1}});
      step_case(1'b0, 43'h3F);
      for (int i = 0; i < 6; i++)
         step_case(1'b0, 43'({xs(), xs()}));
      $display("test binary done");
      // Alarm in binary mode: counter stopped at the last stepped value
      rdcnt(v);
      // Passes through zero matched the reset alarm; start from a clean flag
      wr(`CRTC_OFF_IRQ_CLEAR, 32'h2);
      wr(`CRTC_OFF_IRQ_ENABLE, 32'h2);
      rd(`CRTC_OFF_IRQ_STATUS, q);
      chk("match flag idle", {42'h0, q[1]}, 43'h0);
      setcnt(`CRTC_OFF_ALARM_LO, v);
      rd(`CRTC_OFF_IRQ_STATUS, q);
      chk("match", {42'h0, rtcMatch}, 43'h1);
      chk("match flag", {42'h0, q[1]}, 43'h1);
      chk("irq", {42'h0, irq}, 43'h1);
      wr(`CRTC_OFF_IRQ_ENABLE, 32'h0);
      rd(`CRTC_OFF_IRQ_STATUS, q);
      chk("irq masked", {42'h0, irq}, 43'h0);
      wr(`CRTC_OFF_IRQ_CLEAR, 32'h2);
      wr(`CRTC_OFF_IRQ_ENABLE, 32'h2);
      rd(`CRTC_OFF_IRQ_STATUS, q);
      chk("irq cleared", {42'h0, irq}, 43'h0);
      setcnt(`CRTC_OFF_ALARM_LO, v + 43'h1);
      rd(`CRTC_OFF_IRQ_STATUS, q);
      chk("no match", {42'h0, rtcMatch}, 43'h0);
      // Alarm in calendar mode against the calendar reset value
      wr(`CRTC_OFF_CTRL, 32'h1);
      setcnt(`CRTC_OFF_ALARM_LO, mk(0, 0, 0, 1, 1, 0, 7, 1));
      rd(`CRTC_OFF_IRQ_STATUS, q);
      chk("cal match", {42'h0, rtcMatch}, 43'h1);
      $display("test alarm done");
      // Strobe interrupt
      wr(`CRTC_OFF_IRQ_ENABLE, 32'h1);
      one_tick(1'b1);
      rd(`CRTC_OFF_IRQ_STATUS, q);
      chk("tick irq", {42'h0, irq}, 43'h1);
      $display("test interrupt done");
      final_report();
   end
endmodule
